// ### design/fls_supervisor.sv
// supervisory state machine of an isolated dc/dc power module
// assumes comparator flags are asynchronous to clk, active high
// assumes the analogue side owns thresholds, hysteresis and the rail
// window; every timing count is in cycles of the 100 MHz clock
//
// Contract
// - request high starts switching, runs soft-start, then delivers power
// - request low disables the converter and stops switching
// - latching fault holds device non-switching until valid latch reset
// - request low over 150 us then high clears latch, starts soft-start
// - power_ok_n conducts only with no fault and rails within ten percent
// - input lockouts auto-recover; all other protections latch off
// - latch clears on request toggle or input supply recycle
// - input below lockout falling level enters lockout, stops switching
// - input below analog lockout level clears every protection state
// - leaving lockout starts soft-start if requested, else waits disabled
// - input over-voltage stops switching; recovers via soft-start or disable
// - input over-voltage lockout never clears latched faults
// - either rail below under-voltage level stops, releases ok, latches
// - under-voltage masked in soft-start; unreached level at end trips
// - either rail over ten percent high stops at once and latches
// - fail-safe main output over-voltage shuts down at once, latched
// - overload acts only through the latched under-voltage trip
// - either stage over-temperature stops, releases ok, latches off
// - thermal latch leaves only when cool and after toggle or recycle; a recycle clears it even while hot
// - rail flags deglitched 3 ms during start-up before first power ok
// - main rail below bias level 28.4 ms into soft-start latches off

`timescale 1ns/1ns
`default_nettype none
`include "fls_regs.svh"

module fls_supervisor
  import fls_pkg::*;
#(
  parameter int REQ_LOW_CYC    = `FLS_REQ_LOW_CYC,
  parameter int DEGLITCH_CYC   = `FLS_DEGLITCH_CYC,
  parameter int SS_TIMEOUT_CYC = `FLS_SS_TIMEOUT_CYC,
  parameter int SS_STEP_CYC    = `FLS_SS_STEP_CYC
) (
  // clock and reset
  input  wire logic                    clk,
  input  wire logic                    sys_rst,
  // host side
  input  wire logic                    turn_on_request,
  output logic                         power_ok_n_o,
  output logic                         power_ok_n_oe,
  // input supply comparators
  input  wire logic                    input_low_lockout,
  input  wire logic                    input_analog_low,
  input  wire logic                    input_high_lockout,
  // output rail comparators
  input  wire logic                    main_rail_low,
  input  wire logic                    aux_rail_low,
  input  wire logic                    main_rail_high,
  input  wire logic                    aux_rail_high,
  input  wire logic                    main_rail_in_window,
  input  wire logic                    aux_rail_in_window,
  input  wire logic                    main_bias_ok,
  input  wire logic                    failsafe_high_level,
  // temperature flags
  input  wire logic                    thermal_trip_pri,
  input  wire logic                    thermal_trip_sec,
  // converter control and status
  output logic                         switch_en,
  output logic [2:0]                   soft_start_step,
  output logic                         soft_start_active,
  output logic                         latched_off,
  output logic [`FLS_CAUSE_W-1:0]      fault_cause
);

  localparam int NSYNC = 13;
  localparam int CW    = 32;

  // ---------------------------------------------------------------
  // mode decoding
  // ---------------------------------------------------------------
  // true in every mode in which the converter may switch; shared by
  // the trip qualification and the switch enable so they never drift
  function automatic logic fls_switching(input fls_mode_t m);
    return (m == FLS_SOFT_START) || (m == FLS_SETTLE) ||
           (m == FLS_NORMAL);
  endfunction

  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  typedef struct packed {
    logic [NSYNC-1:0]        sync1;
    logic [NSYNC-1:0]        sync2;
    fls_mode_t               mode;
    logic [CW-1:0]           low_cnt;
    logic                    low_done;
    logic                    req_d;
    logic [CW-1:0]           ss_cnt;
    logic [CW-1:0]           step_cnt;
    logic [2:0]              step;
    logic [CW-1:0]           dg_cnt;
    logic                    ok_seen;
    logic                    ok;
    logic                    sw;
    logic [`FLS_CAUSE_W-1:0] cause;
  } fls_state_t;

  fls_state_t st_ff;
  fls_state_t nxt_st;

  // synchronised flag views
  logic s_req, s_ilow, s_ialow, s_ihigh, s_mlow, s_alow, s_mhigh, s_ahigh;
  logic s_mwin, s_awin, s_bias, s_fsov, s_therm;
  logic [NSYNC-1:0] raw_flags;

  assign raw_flags = {turn_on_request, input_low_lockout, input_analog_low,
                      input_high_lockout, main_rail_low, aux_rail_low,
                      main_rail_high, aux_rail_high, main_rail_in_window,
                      aux_rail_in_window, main_bias_ok, failsafe_high_level,
                      thermal_trip_pri | thermal_trip_sec};

  // each flag passes two flops before any decision sees it; the first
  // stage may still be settling, so nothing but the second stage reads it
  // only the second stage is read
  assign {s_req, s_ilow, s_ialow, s_ihigh, s_mlow, s_alow, s_mhigh, s_ahigh,
          s_mwin, s_awin, s_bias, s_fsov, s_therm} = st_ff.sync2;

  // ---------------------------------------------------------------
  // next state
  // ---------------------------------------------------------------
  always_comb begin
    logic lockout;
    logic uv_trip;
    logic ov_trip;
    logic [`FLS_CAUSE_W-1:0] trip;
    logic req_rise;
    nxt_st = st_ff;
    nxt_st.sync1 = raw_flags;
    nxt_st.sync2 = st_ff.sync1;
    nxt_st.req_d = s_req;
    req_rise = s_req & ~st_ff.req_d;
    lockout = s_ilow | s_ihigh;
    uv_trip = s_mlow | s_alow;
    ov_trip = s_mhigh | s_ahigh;
    trip = `FLS_CAUSE_RST;

    // request low timer for latch release
    // the done flag survives the rising cycle itself, so the latch sees
    // it together with the edge, and is dropped one cycle later
    if (s_req) begin
      nxt_st.low_cnt = '0;
    end else if (!st_ff.low_done) begin
      nxt_st.low_cnt = st_ff.low_cnt + CW'(1);
      if (st_ff.low_cnt >= CW'(REQ_LOW_CYC)) begin
        nxt_st.low_done = 1'b1;
      end
    end
    if (s_req && !req_rise) begin
      nxt_st.low_done = 1'b0;
    end

    // latching trip causes while switching; the flags are levels, so a
    // trip that lands with a request edge or a lockout still wins
    if (fls_switching(st_ff.mode)) begin
      if (s_fsov) begin
        trip[`FLS_CAUSE_FSOV] = 1'b1;
      end
      if (s_therm) begin
        trip[`FLS_CAUSE_THERM] = 1'b1;
      end
    end
    // time-out runs from the start of soft start through settling, so it
    // still bites when the reference steps end before it runs out
    if ((st_ff.mode == FLS_SOFT_START || st_ff.mode == FLS_SETTLE) &&
        st_ff.ss_cnt >= CW'(SS_TIMEOUT_CYC) && !s_bias) begin
      trip[`FLS_CAUSE_SSTO] = 1'b1;
    end
    // a rail still below its level as the last step ends trips at once
    if (st_ff.mode == FLS_SOFT_START &&
        st_ff.step == 3'(`FLS_SS_STEPS - 1) &&
        st_ff.step_cnt >= CW'(SS_STEP_CYC - 1) && uv_trip) begin
      trip[`FLS_CAUSE_SSUV] = 1'b1;
    end
    // rail checks masked in soft start, deglitched while settling
    if (st_ff.mode == FLS_SETTLE && st_ff.dg_cnt >= CW'(DEGLITCH_CYC)) begin
      if (uv_trip) begin
        trip[`FLS_CAUSE_SSUV] = 1'b1;
      end
      if (ov_trip) begin
        trip[`FLS_CAUSE_OV] = 1'b1;
      end
    end
    if (st_ff.mode == FLS_NORMAL) begin
      if (uv_trip) begin
        trip[`FLS_CAUSE_UV] = 1'b1;
      end
      if (ov_trip) begin
        trip[`FLS_CAUSE_OV] = 1'b1;
      end
    end

    // timers
    nxt_st.ss_cnt = '0;
    nxt_st.step_cnt = '0;
    nxt_st.dg_cnt = '0;

    // mode sequencing; analog recycle first, then trips, then the rest
    // the recycle wipes every cause; a trip only ever adds cause bits
    if (s_ialow) begin
      nxt_st.mode = FLS_LOCKOUT;
      nxt_st.cause = `FLS_CAUSE_RST;
      nxt_st.step = '0;
    end else if (|trip) begin
      nxt_st.mode = FLS_LATCHED;
      nxt_st.cause = st_ff.cause | trip;
    end else begin
      case (st_ff.mode)
        FLS_LOCKOUT: begin
          // auto-recovery: leave once both input lockouts have cleared
          if (!lockout) begin
            nxt_st.mode = s_req ? FLS_SOFT_START : FLS_DISABLED;
            nxt_st.step = '0;
          end
        end
        FLS_DISABLED: begin
          if (lockout) begin
            nxt_st.mode = FLS_LOCKOUT;
          end else if (s_req) begin
            nxt_st.mode = FLS_SOFT_START;
            nxt_st.step = '0;
          end
        end
        FLS_SOFT_START: begin
          // seven reference steps of equal length, then settling
          nxt_st.ss_cnt = st_ff.ss_cnt + CW'(1);
          nxt_st.step_cnt = st_ff.step_cnt + CW'(1);
          if (lockout) begin
            nxt_st.mode = FLS_LOCKOUT;
          end else if (!s_req) begin
            nxt_st.mode = FLS_DISABLED;
          end else if (st_ff.step_cnt >= CW'(SS_STEP_CYC - 1)) begin
            nxt_st.step_cnt = '0;
            if (st_ff.step == 3'(`FLS_SS_STEPS - 1)) begin
              nxt_st.mode = FLS_SETTLE;
            end else begin
              nxt_st.step = st_ff.step + 3'h1;
            end
          end
        end
        FLS_SETTLE: begin
          // time-out keeps counting through settling, bias level reached or not
          nxt_st.ss_cnt = st_ff.ss_cnt + CW'(1);
          // deglitch runs once both rails are back above their levels
          if (!uv_trip) begin
            nxt_st.dg_cnt = st_ff.dg_cnt + CW'(1);
          end
          if (lockout) begin
            nxt_st.mode = FLS_LOCKOUT;
          end else if (!s_req) begin
            nxt_st.mode = FLS_DISABLED;
          end else if (st_ff.dg_cnt >= CW'(DEGLITCH_CYC)) begin
            nxt_st.mode = FLS_NORMAL;
            nxt_st.ok_seen = 1'b1;
          end
        end
        FLS_NORMAL: begin
          if (lockout) begin
            nxt_st.mode = FLS_LOCKOUT;
          end else if (!s_req) begin
            nxt_st.mode = FLS_DISABLED;
          end
        end
        FLS_LATCHED: begin
          // input high lockout leaves the latch alone
          if (req_rise && st_ff.low_done && !s_therm && !s_fsov) begin
            nxt_st.mode = FLS_SOFT_START;
            // a release inside an input lockout waits there instead
            if (lockout) begin
              nxt_st.mode = FLS_LOCKOUT;
            end
            nxt_st.cause = `FLS_CAUSE_RST;
            nxt_st.step = '0;
          end
        end
        default: begin
          nxt_st.mode = FLS_LOCKOUT;
        end
      endcase
    end

    // outputs follow the next mode
    nxt_st.sw = fls_switching(nxt_st.mode);
    nxt_st.ok = (nxt_st.mode == FLS_NORMAL) && s_mwin && s_awin;
    if (nxt_st.mode != FLS_NORMAL && nxt_st.mode != FLS_SETTLE) begin
      nxt_st.ok_seen = 1'b0;
    end
  end

  // ---------------------------------------------------------------
  // state register
  // ---------------------------------------------------------------
  // sync reset parks the block in lockout with every latch and timer
  // clear; switching and power ok stay off while reset is held
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      st_ff <= '{sync1: '0, sync2: '0, mode: FLS_LOCKOUT, low_cnt: '0,
                 low_done: 1'b0, req_d: 1'b0, ss_cnt: '0, step_cnt: '0,
                 step: '0, dg_cnt: '0, ok_seen: 1'b0, ok: 1'b0, sw: 1'b0,
                 cause: `FLS_CAUSE_RST};
    end else begin
      st_ff <= nxt_st;
    end
  end

  // ---------------------------------------------------------------
  // outputs
  // ---------------------------------------------------------------
  // every output comes from the state register or a decode of it, so
  // no comparator glitch reaches the pins within a cycle
  assign power_ok_n_o      = 1'b0;           // open drain pulls low only
  assign power_ok_n_oe     = st_ff.ok;
  assign switch_en         = st_ff.sw;
  assign soft_start_step   = st_ff.step;
  assign soft_start_active = (st_ff.mode == FLS_SOFT_START);
  assign latched_off       = (st_ff.mode == FLS_LATCHED);
  assign fault_cause       = st_ff.cause;

endmodule
`default_nettype wire

// ### design/fls_regs.svh
// fault latch supervisor constants: timing counts and field positions
// assumes a 100 MHz clock; included by bare name
`ifndef FLS_REGS_SVH
`define FLS_REGS_SVH

// ---------------------------------------------------------------
// timing
// ---------------------------------------------------------------
`define FLS_CLK_MHZ           100
`define FLS_REQ_LOW_US        150
`define FLS_REQ_LOW_CYC       (`FLS_REQ_LOW_US * `FLS_CLK_MHZ)
`define FLS_DEGLITCH_US       3000
`define FLS_DEGLITCH_CYC      (`FLS_DEGLITCH_US * `FLS_CLK_MHZ)
`define FLS_SS_TIMEOUT_US     28400
`define FLS_SS_TIMEOUT_CYC    (`FLS_SS_TIMEOUT_US * `FLS_CLK_MHZ)
`define FLS_SS_STEP_US        128
`define FLS_SS_STEP_CYC       (`FLS_SS_STEP_US * `FLS_CLK_MHZ)
`define FLS_SS_STEPS          7

// ---------------------------------------------------------------
// latched fault cause fields
// ---------------------------------------------------------------
`define FLS_CAUSE_W           6
`define FLS_CAUSE_UV          0
`define FLS_CAUSE_OV          1
`define FLS_CAUSE_FSOV        2
`define FLS_CAUSE_THERM       3
`define FLS_CAUSE_SSTO        4
`define FLS_CAUSE_SSUV        5
`define FLS_CAUSE_RST         6'h00

`endif

// ### design/fls_pkg.sv
// fault latch supervisor types
// assumes fls_regs.svh is available on the include path
package fls_pkg;

  // operating modes of the supervisor
  typedef enum logic [2:0] {
    FLS_LOCKOUT,
    FLS_DISABLED,
    FLS_SOFT_START,
    FLS_SETTLE,
    FLS_NORMAL,
    FLS_LATCHED
  } fls_mode_t;

endpackage

// ### verification/fls_supervisor_properties.sv
// ---------------------------------------------------------------
// port checker for the fault latch supervisor
// ---------------------------------------------------------------
// assumes bind onto fls_supervisor; one clock, sync active-high reset
`timescale 1ns/1ns
`default_nettype none
module fls_sup_props (
  // clock and reset
  input wire logic       clk,
  input wire logic       sys_rst,
  // inputs watched
  input wire logic       turn_on_request,
  input wire logic       input_low_lockout,
  input wire logic       input_analog_low,
  input wire logic       input_high_lockout,
  input wire logic       main_rail_low,
  input wire logic       aux_rail_low,
  input wire logic       main_rail_high,
  input wire logic       aux_rail_high,
  input wire logic       main_rail_in_window,
  input wire logic       aux_rail_in_window,
  input wire logic       failsafe_high_level,
  input wire logic       thermal_trip_pri,
  input wire logic       thermal_trip_sec,
  // outputs watched
  input wire logic       power_ok_n_o,
  input wire logic       power_ok_n_oe,
  input wire logic       switch_en,
  input wire logic [2:0] soft_start_step,
  input wire logic       soft_start_active,
  input wire logic       latched_off
);
  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);

  // latch, trips, lockouts and power ok
  a_latch_stays_off: assert property (latched_off |-> !switch_en && !power_ok_n_oe)
    else $error("switching or ok while latched");
  a_ok_pin_low: assert property (power_ok_n_oe |-> switch_en && !power_ok_n_o)
    else $error("power ok without switching");
  a_ok_window: assert property ((!main_rail_in_window ||
    !aux_rail_in_window) [*3] |=> !power_ok_n_oe)
    else $error("power ok with a rail out of window");
  a_soft_start_run: assert property (soft_start_active |-> switch_en && soft_start_step <= 3'h6)
    else $error("soft start step or switching wrong");
  a_rail_trip: assert property (power_ok_n_oe && !input_analog_low && (main_rail_low || aux_rail_low || main_rail_high || aux_rail_high) |-> ##[1:4] latched_off)
    else $error("rail trip did not latch");
  a_hard_trip: assert property (switch_en && !input_analog_low && (failsafe_high_level || thermal_trip_pri || thermal_trip_sec) |-> ##[1:4] latched_off)
    else $error("failsafe or thermal trip did not latch");
  a_req_low_off: assert property ($fell(turn_on_request) |-> ##[1:4] !switch_en)
    else $error("request low kept switching");
  a_latch_held: assert property ((latched_off && !input_analog_low && !turn_on_request) [*3] |=> latched_off)
    else $error("latch left without reset");
  a_analog_clear: assert property (input_analog_low [*3] |=> !latched_off && !switch_en)
    else $error("analog low did not clear");
  a_lockouts_stop: assert property ((input_low_lockout || input_high_lockout) [*3] |=> !switch_en)
    else $error("lockout kept switching");

  // main scenarios reached
  c_latched: cover property ($rose(latched_off));
  c_ok: cover property ($rose(power_ok_n_oe));
  c_last_step: cover property (soft_start_step == 3'h6);
endmodule

bind fls_supervisor fls_sup_props i_fls_sup_props (
  .clk, .sys_rst, .turn_on_request, .input_low_lockout, .input_analog_low,
  .input_high_lockout, .main_rail_low, .aux_rail_low, .main_rail_high,
  .aux_rail_high, .main_rail_in_window, .aux_rail_in_window,
  .failsafe_high_level, .thermal_trip_pri,
  .thermal_trip_sec, .power_ok_n_o, .power_ok_n_oe, .switch_en,
  .soft_start_step, .soft_start_active, .latched_off
);
`default_nettype wire

// ### verification/fls_host_model.sv
// ---------------------------------------------------------------
// host controller model: drives the request, reads power ok
// ---------------------------------------------------------------
// assumes the power ok pin has a pull-up; commands come from the bench
`timescale 1ns/1ns
`default_nettype none
module fls_host_model #(
  parameter int LOW_CYC = 30
) (
  // clock and commands
  input  wire logic clk,
  input  wire logic want_on,
  input  wire logic clear_latch,
  // power ok pin parts and request
  input  wire logic power_ok_n_o,
  input  wire logic power_ok_n_oe,
  output var logic  turn_on_request,
  output logic      pg_pin
);
  int cnt = 0;
  logic on_q = 1'b0, clr_q = 1'b0;

  // commands taken at the rising edge, clear of the bench's falling edge
  always @(posedge clk) begin
    on_q <= want_on;
    clr_q <= clear_latch;
  end

  // pull-up wins unless the device conducts
  assign pg_pin = power_ok_n_oe ? power_ok_n_o : 1'b1;

  // latch reset holds request low long enough, then high
  initial turn_on_request = 1'b0;
  always @(negedge clk) begin
    if (cnt != 0) begin
      cnt <= cnt - 1;
      turn_on_request <= (cnt == 1);
    end else if (clr_q) begin
      cnt <= LOW_CYC;
      turn_on_request <= 1'b0;
    end else begin
      turn_on_request <= on_q;
    end
  end
endmodule
`default_nettype wire

// ### verification/test_fault_latch_supervisor.sv
// ---------------------------------------------------------------
// self-checking bench of the fault latch supervisor
// ---------------------------------------------------------------
// assumes short timing parameters; inputs change on the falling edge
`timescale 1ns/1ns
`default_nettype none
module test_fault_latch_supervisor;
  import fls_pkg::*;
  logic clk = 0, sys_rst = 1, want_on = 0, clr = 0, req, pin, o, oe;
  logic ilo = 0, ian = 0, ihi = 0, mlo = 0, alo = 0, mhi = 0, ahi = 0;
  logic fs = 0, tp = 0, ts = 0, sw, ssa, lat;
  logic win_m = 1, win_a = 1, bias = 1;
  logic [2:0] step;
  logic [5:0] cause;
  int miscompares = 0, checks = 0, cyc = 0, i, r;
  logic [6:0] flt [7] = '{7'h40, 7'h20, 7'h10, 7'h08, 7'h04, 7'h02, 7'h01};
  int bitn [7] = '{0, 0, 1, 1, 2, 3, 3};

  fls_supervisor #(.REQ_LOW_CYC(20), .DEGLITCH_CYC(30),
    .SS_TIMEOUT_CYC(50), .SS_STEP_CYC(10)) i_fls_supervisor (
    .clk(clk), .sys_rst(sys_rst), .turn_on_request(req),
    .power_ok_n_o(o), .power_ok_n_oe(oe), .input_low_lockout(ilo),
    .input_analog_low(ian), .input_high_lockout(ihi),
    .main_rail_low(mlo), .aux_rail_low(alo), .main_rail_high(mhi),
    .aux_rail_high(ahi), .main_rail_in_window(win_m),
    .aux_rail_in_window(win_a), .main_bias_ok(bias),
    .failsafe_high_level(fs), .thermal_trip_pri(tp),
    .thermal_trip_sec(ts), .switch_en(sw), .soft_start_step(step),
    .soft_start_active(ssa), .latched_off(lat), .fault_cause(cause));
  fls_host_model #(.LOW_CYC(25)) i_fls_host_model (.clk(clk),
    .want_on(want_on), .clear_latch(clr), .power_ok_n_o(o),
    .power_ok_n_oe(oe), .turn_on_request(req), .pg_pin(pin));

  // clock and cycle ceiling
  initial forever #5 clk = ~clk;
  always @(posedge clk) begin
    cyc++;
    if (cyc == 6000) begin
      miscompares++;
      report_and_stop();
    end
  end

  task automatic chk(input string n, input logic s, input logic e);
    checks++;
    if (s !== e) begin
      miscompares++;
      $display("BAD %s expected %b seen %b", n, e, s);
    end
  endtask
  task automatic wt(input int n);
    repeat (n) @(negedge clk);
  endtask
  task automatic power_up();
    want_on = 1;
    for (i = 0; i < 400 && oe !== 1'b1; i++) wt(1);
    wt(1);
    chk("pg_pin", pin, 1'b0);
  endtask
  task automatic report_and_stop();
    $display("miscompares %0d checks %0d", miscompares, checks);
    if (miscompares == 0 && checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask

  initial begin
    wt(20);
    chk("rst_sw", sw, 1'b0);
    chk("rst_oe", oe, 1'b0);
    sys_rst = 0;
    wt(8);
    chk("disabled", sw, 1'b0);
    power_up();
    chk("ok_delay", i >= 100, 1'b1);
    // either rail out of window opens the pin, back in closes it
    for (r = 0; r < 2; r++) begin
      {win_m, win_a} = r ? 2'b01 : 2'b10;
      wt(4);
      chk("win_open", pin, 1'b1);
      {win_m, win_a} = 2'b11;
      wt(4);
      chk("win_ok", pin, 1'b0);
    end
    // one fault per row: latch, cause bit, then timed request reset
    for (r = 0; r < 7; r++) begin
      power_up();
      {mlo, alo, mhi, ahi, fs, tp, ts} = flt[r];
      wt(6);
      chk("latched", lat, 1'b1);
      chk("pin_open", pin, 1'b1);
      chk("cause", cause[bitn[r]], 1'b1);
      {mlo, alo, mhi, ahi, fs, tp, ts} = 7'h00;
      clr = 1;
      wt(1);
      clr = 0;
      wt(30);
      chk("restart", ssa, 1'b1);
    end
    // short toggle and input over-voltage keep the latch
    tp = 1;
    wt(6);
    tp = 0;
    want_on = 0;
    wt(10);
    want_on = 1;
    ihi = 1;
    wt(10);
    ihi = 0;
    wt(6);
    chk("short_low", lat, 1'b1);
    ian = 1;
    wt(5);
    chk("analog_clr", lat, 1'b0);
    ian = 0;
    wt(6);
    chk("lock_exit", ssa, 1'b1);
    // input lockouts stop and auto-recover
    for (r = 0; r < 2; r++) begin
      power_up();
      {ilo, ihi} = r ? 2'b01 : 2'b10;
      wt(6);
      chk("lock_sw", sw, 1'b0);
      chk("lock_lat", lat, 1'b0);
      {ilo, ihi} = 2'b00;
      wt(6);
      chk("lock_ss", ssa, 1'b1);
    end
    // rail still low when soft start ends
    mlo = 1;
    wt(120);
    chk("ss_uv", cause[5], 1'b1);
    mlo = 0;
    clr = 1;
    wt(1);
    clr = 0;
    wt(30);
    power_up();
    want_on = 0;
    wt(6);
    chk("req_off", sw, 1'b0);
    // main rail never reaches its bias level: soft start times out
    bias = 0;
    want_on = 1;
    wt(60);
    chk("ss_timeout", lat, 1'b1);
    chk("ss_to_cause", cause[4], 1'b1);
    // reset in mid-run drops the latch, then a clean restart
    bias = 1;
    sys_rst = 1;
    wt(2);
    chk("mid_rst_lat", lat, 1'b0);
    chk("mid_rst_sw", sw, 1'b0);
    sys_rst = 0;
    power_up();
    report_and_stop();
  end
endmodule
`default_nettype wire
